// [core/sdms_consts.vh]
`ifndef SDMS_CONSTS_VH
`define SDMS_CONSTS_VH
// Register offsets (byte addresses)
`define SDMS_REG_MODE      8'h00
`define SDMS_REG_OPREQ     8'h04
`define SDMS_REG_HOME      8'h08
`define SDMS_REG_CTRL      8'h0C
`define SDMS_REG_SCNUM     8'h10
`define SDMS_REG_SCDEN     8'h14
`define SDMS_REG_TVEL      8'h18
`define SDMS_REG_STAT      8'h1C
`define SDMS_REG_SETUP     8'h20
// Mode register fields
`define SDMS_MODE_CODE_HI  3
`define SDMS_MODE_SPEC_BIT 4
`define SDMS_MODE_CL_BIT   5
// Mode code fields
`define SDMS_CODE_LOOP_BIT 3
// Reset values
`define SDMS_RST_MODE      6'h00
`define SDMS_RST_OPMODE    8'h01
`define SDMS_RST_SCALE     16'h0001
// Operating mode codes
`define SDMS_OP_PP         8'h01
`define SDMS_OP_VL         8'h02
`define SDMS_OP_PT         8'h04
`define SDMS_OP_CST        8'h0A
`define SDMS_OP_CLKDIR     8'hFF
`define SDMS_OP_HOMING     8'h06
// Speeds in rpm
`define SDMS_VMAX_HI_RPM   24'h0003E8
`define SDMS_VMAX_LO_RPM   24'h000064
`define SDMS_TEST_RPM      32'h0000001E
// Analog levels in mV
`define SDMS_VFS_MV        32'h00002710
`define SDMS_DEAD_MV       32'h00000014
// Control word pattern for operation enabled
`define SDMS_CTRL_ENOP     4'hF
`endif

// [core/sdms_top.v]
// Behaviour
// - A successful auto setup stores its results under the drive and tuning categories.
// - In a special mode the power stage follows only the enable pin, not the control word.
// - Codes 00-07 open loop, 08-0F closed; each: clock-dir, test run, analog, joystick.
// - Analog codes use 1000 rpm maximum for the even code and 100 rpm for the odd code.
// - Clock-direction codes set that operating mode and pass step and direction through.
// - Analog codes select velocity mode and keep the target velocity following the voltage.
// - The analog maximum speed is rescaled by a numerator and a denominator.
// - In normal analog mode full-scale voltage maps to the maximum speed.
// - In normal analog mode the sign comes from the direction pin.
// - In normal analog mode voltages from zero to the dead-zone threshold command zero speed.
// - In joystick mode mid-scale is zero speed, lower is negative and higher is positive.
// - In joystick mode voltages within the dead zone around mid-scale command zero speed.
// - In a test run the motor turns at 30 rpm in the coded direction while enable is set.
// - Profile torque and cyclic synchronous torque requests are rejected in open loop.
// - In open loop the homing-on-block methods are rejected, other methods stay allowed.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`include "sdms_consts.vh"
module sdms_top #(
  parameter ADC_W       = 12,
  parameter HOME_BLK_LO = -4,
  parameter HOME_BLK_HI = -1
) (
  input  wire             CLOCK,
  input  wire             RSTN,
  input  wire [7:0]       ADDR,
  input  wire [31:0]      WDATA,
  input  wire             WR,
  input  wire             RD,
  output reg  [31:0]      RDATA,
  input  wire             EN_PIN,
  input  wire             DIR_PIN,
  input  wire             STEP_PIN,
  input  wire [ADC_W-1:0] ADC_CODE,
  input  wire             SETUP_OK,
  input  wire [31:0]      SETUP_RESULT,
  output reg  [31:0]      TARGET_VEL,
  output reg  [7:0]       OP_MODE,
  output reg              CLOSED_LOOP,
  output reg              POWER_EN,
  output reg              STEP_OUT,
  output reg              DIR_OUT,
  output reg              STORE_DRIVE,
  output reg              STORE_TUNING
);
  // Analog full scale and mid-scale in ADC counts
  localparam [ADC_W-1:0] FULL = {ADC_W{1'b1}};
  localparam [ADC_W-1:0] MID  = FULL >> 1;
  // Dead zone in ADC counts, rounded down
  localparam integer DEAD_I = (`SDMS_DEAD_MV * ((1 << ADC_W) - 1)) / `SDMS_VFS_MV;
  localparam [ADC_W-1:0] DEAD = DEAD_I[ADC_W-1:0];
  localparam signed [7:0] HLO = HOME_BLK_LO[7:0];
  localparam signed [7:0] HHI = HOME_BLK_HI[7:0];
  // Mode classes, one-hot
  localparam [3:0] M_CLK = 4'b0001;
  localparam [3:0] M_TST = 4'b0010;
  localparam [3:0] M_ANA = 4'b0100;
  localparam [3:0] M_JOY = 4'b1000;

  // Software-visible registers and reject flags
  reg  [5:0]       mode_r;
  reg  [7:0]       opreq_r;
  reg              oprej_r;
  reg  [7:0]       home_r;
  reg              homerej_r;
  reg  [3:0]       ctrl_r;
  reg  [15:0]      scnum_r;
  reg  [15:0]      scden_r;
  reg  [31:0]      setup_r;

  // Pin synchronisers, two stages each
  reg  [1:0]       en_s_r;
  reg  [1:0]       dir_s_r;
  reg  [1:0]       step_s_r;

  // Combinational decode and analog results
  reg  [3:0]       mclass;
  reg  [31:0]      vel_nxt;
  reg  [ADC_W-1:0] mag;
  reg              neg;
  reg  [ADC_W-1:0] span;
  reg  [ADC_W-1:0] eff;
  reg  [7:0]       op_nxt;

  // Special mode flag, mode code and loop selection
  wire        spec_act = mode_r[`SDMS_MODE_SPEC_BIT];
  wire [3:0]  code     = mode_r[`SDMS_MODE_CODE_HI:0];
  wire        loop_cl  = spec_act ? code[`SDMS_CODE_LOOP_BIT]
                                  : mode_r[`SDMS_MODE_CL_BIT];

  // Synchronised pin levels, second stage only
  wire        en_s     = en_s_r[1];
  wire        dir_s    = dir_s_r[1];
  wire        step_s   = step_s_r[1];

  // A zero denominator is taken as one
  wire [15:0] den      = (scden_r == 16'h0000) ? `SDMS_RST_SCALE : scden_r;
  // Even code 1000 rpm, odd code 100 rpm, then scaled
  wire [23:0] vbase    = code[0] ? `SDMS_VMAX_LO_RPM : `SDMS_VMAX_HI_RPM;
  wire [39:0] vprod    = {16'h0000, vbase} * {24'h000000, scnum_r};
  wire [39:0] vmax40   = vprod / {24'h000000, den};
  wire [23:0] vmax     = vmax40[23:0];
  wire [47:0] sprod    = {{(48-ADC_W){1'b0}}, eff} * {24'h000000, vmax};
  wire [47:0] squot    = sprod / {{(48-ADC_W){1'b0}}, span};
  wire [31:0] smag     = squot[31:0];

  // Status word as read back by software
  wire [31:0] stat_word = {16'h0000, OP_MODE, 2'b00, homerej_r, oprej_r,
                           POWER_EN, CLOSED_LOOP, spec_act, en_s};

  // Torque modes are refused without feedback
  function rej_op;
    input [7:0] m;
    input       cl;
    begin
      rej_op = !cl && (m == `SDMS_OP_PT || m == `SDMS_OP_CST);
    end
  endfunction

  // Homing on block is refused without feedback
  function rej_home;
    input [7:0] m;
    input       cl;
    begin
      rej_home = !cl && ($signed(m) >= HLO) && ($signed(m) <= HHI);
    end
  endfunction

  // Magnitudes inside the dead zone command no motion
  function [ADC_W-1:0] dead_cut;
    input [ADC_W-1:0] m;
    begin
      dead_cut = (m <= DEAD) ? {ADC_W{1'b0}} : m;
    end
  endfunction

  // Two-flop synchronisers; only stage 2 feeds logic
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      en_s_r   <= 2'h0;
      dir_s_r  <= 2'h0;
      step_s_r <= 2'h0;
    end else begin
      en_s_r   <= {en_s_r[0], EN_PIN};
      dir_s_r  <= {dir_s_r[0], DIR_PIN};
      step_s_r <= {step_s_r[0], STEP_PIN};
    end
  end

  // Mode code decode into classes
  always @* begin
    case (code[2:1])
      2'b00:   mclass = M_CLK;
      2'b01:   mclass = M_TST;
      2'b10:   mclass = M_ANA;
      2'b11:   mclass = M_JOY;
      default: mclass = M_CLK;
    endcase
  end

  // Analog magnitude, sign and dead zone
  always @* begin
    mag  = {ADC_W{1'b0}};
    neg  = 1'b0;
    span = FULL;
    eff  = {ADC_W{1'b0}};
    if (mclass == M_JOY) begin
      // Joystick: distance from mid-scale, sign from the side of it
      span = MID;
      if (ADC_CODE >= MID) begin
        mag = ADC_CODE - MID;
        neg = 1'b0;
      end else begin
        mag = MID - ADC_CODE;
        neg = 1'b1;
      end
      eff = dead_cut(mag);
    end else begin
      // Normal: voltage gives the magnitude, the direction pin the sign
      mag = ADC_CODE;
      neg = dir_s;
      eff = dead_cut(mag);
    end
    // Clip to the span so the scaled speed never passes the maximum
    if (eff > span)
      eff = span;
  end

  // Target velocity and effective operating mode
  always @* begin
    vel_nxt = 32'h00000000;
    op_nxt  = opreq_r;
    if (spec_act) begin
      case (mclass)
        M_CLK: begin
          op_nxt = `SDMS_OP_CLKDIR;
        end
        M_TST: begin
          op_nxt = `SDMS_OP_CLKDIR;
          if (en_s)
            vel_nxt = code[0] ? (32'h00000000 - `SDMS_TEST_RPM)
                              : `SDMS_TEST_RPM;
        end
        M_ANA, M_JOY: begin
          op_nxt  = `SDMS_OP_VL;
          vel_nxt = neg ? (32'h00000000 - smag) : smag;
        end
        default: begin
          op_nxt = `SDMS_OP_CLKDIR;
        end
      endcase
    end
  end

  // Register writes and auto setup capture
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      mode_r    <= `SDMS_RST_MODE;
      opreq_r   <= `SDMS_RST_OPMODE;
      oprej_r   <= 1'b0;
      home_r    <= 8'h00;
      homerej_r <= 1'b0;
      ctrl_r    <= 4'h0;
      scnum_r   <= `SDMS_RST_SCALE;
      scden_r   <= `SDMS_RST_SCALE;
      setup_r   <= 32'h00000000;
    end else begin
      // Refused requests keep the old value and raise their flag
      if (WR) begin
        case (ADDR)
          `SDMS_REG_MODE:  mode_r <= WDATA[5:0];
          `SDMS_REG_OPREQ: begin
            oprej_r <= rej_op(WDATA[7:0], loop_cl);
            if (!rej_op(WDATA[7:0], loop_cl))
              opreq_r <= WDATA[7:0];
          end
          `SDMS_REG_HOME: begin
            homerej_r <= rej_home(WDATA[7:0], loop_cl);
            if (!rej_home(WDATA[7:0], loop_cl))
              home_r <= WDATA[7:0];
          end
          `SDMS_REG_CTRL: begin
            if (!spec_act)
              ctrl_r <= WDATA[3:0];
          end
          `SDMS_REG_SCNUM: scnum_r <= WDATA[15:0];
          `SDMS_REG_SCDEN: scden_r <= WDATA[15:0];
          default: ;
        endcase
      end
      // A finished setup loads its result; software has no write path to it
      if (SETUP_OK)
        setup_r <= SETUP_RESULT;
    end
  end

  // Outputs from flip-flops
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      TARGET_VEL   <= 32'h00000000;
      OP_MODE      <= `SDMS_RST_OPMODE;
      CLOSED_LOOP  <= 1'b0;
      POWER_EN     <= 1'b0;
      STEP_OUT     <= 1'b0;
      DIR_OUT      <= 1'b0;
      STORE_DRIVE  <= 1'b0;
      STORE_TUNING <= 1'b0;
    end else begin
      TARGET_VEL   <= vel_nxt;
      OP_MODE      <= op_nxt;
      CLOSED_LOOP  <= loop_cl;
      // Enable pin in special modes, control word otherwise
      POWER_EN     <= spec_act ? en_s
                               : (ctrl_r == `SDMS_CTRL_ENOP);
      STEP_OUT     <= spec_act && (mclass == M_CLK) && step_s;
      DIR_OUT      <= spec_act && (mclass == M_CLK) && dir_s;
      STORE_DRIVE  <= SETUP_OK;
      STORE_TUNING <= SETUP_OK;
    end
  end

  // Read data, one cycle after the strobe
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= 32'h00000000;
    end else if (RD) begin
      case (ADDR)
        `SDMS_REG_MODE:  RDATA <= {26'h0000000, mode_r};
        `SDMS_REG_OPREQ: RDATA <= {24'h000000, opreq_r};
        `SDMS_REG_HOME:  RDATA <= {24'h000000, home_r};
        `SDMS_REG_CTRL:  RDATA <= {28'h0000000, ctrl_r};
        `SDMS_REG_SCNUM: RDATA <= {16'h0000, scnum_r};
        `SDMS_REG_SCDEN: RDATA <= {16'h0000, scden_r};
        `SDMS_REG_TVEL:  RDATA <= TARGET_VEL;
        `SDMS_REG_STAT:  RDATA <= stat_word;
        `SDMS_REG_SETUP: RDATA <= setup_r;
        default:         RDATA <= 32'h00000000;
      endcase
    end else begin
      RDATA <= 32'h00000000;
    end
  end
endmodule // sdms_top

// [tb/sdms_properties.sv]
`timescale 1ns/1ns
// Port checks of the drive mode block
module sdms_props (
  input wire        CLOCK,
  input wire        RSTN,
  input wire [7:0]  ADDR,
  input wire [31:0] WDATA,
  input wire        WR,
  input wire        EN_PIN,
  input wire        SETUP_OK,
  input wire [31:0] TARGET_VEL,
  input wire [7:0]  OP_MODE,
  input wire        CLOSED_LOOP,
  input wire        POWER_EN,
  input wire        STEP_OUT,
  input wire        DIR_OUT,
  input wire        STORE_TUNING
);
  reg [2:0] ff_r;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // History of clock-direction reporting
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) ff_r <= 3'h0;
    else ff_r <= {ff_r[1:0], OP_MODE == 8'hFF};
  end
  sequence mode_wr;
    WR && ADDR == 8'h00 && WDATA[4];
  endsequence
  sequence trq_req;
    WR && ADDR == 8'h04 && !CLOSED_LOOP && (WDATA[7:0] == 8'h04 || WDATA[7:0] == 8'h0A);
  endsequence
  store_pulse_a: assert property (SETUP_OK |=> STORE_TUNING)
    else $error("store pulse missing");
  store_cause_a: assert property (STORE_TUNING |-> $past(SETUP_OK))
    else $error("store pulse without setup");
  power_pin_a: assert property (
      ff_r == 3'h7 && OP_MODE == 8'hFF |-> POWER_EN == $past(EN_PIN, 3))
    else $error("power stage not following enable");
  loop_code_a: assert property (mode_wr |-> ##2 CLOSED_LOOP == $past(WDATA[3], 2))
    else $error("loop bit wrong");
  step_gate_a: assert property (STEP_OUT || DIR_OUT |-> OP_MODE == 8'hFF)
    else $error("step passed outside clock mode");
  vel_source_a: assert property (
      TARGET_VEL != 32'h0 |-> OP_MODE == 8'hFF || OP_MODE == 8'h02)
    else $error("speed outside speed modes");
  vel_bound_a: assert property (
      OP_MODE == 8'h02 |-> $signed(TARGET_VEL) <= 1000 && $signed(TARGET_VEL) >= -1000)
    else $error("speed above maximum");
  torque_block_a: assert property (
      trq_req |-> ##2 OP_MODE != 8'h04 && OP_MODE != 8'h0A)
    else $error("torque mode taken in open loop");
endmodule // sdms_props
bind sdms_top sdms_props i_props (.CLOCK(CLOCK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .EN_PIN(EN_PIN), .SETUP_OK(SETUP_OK), .TARGET_VEL(TARGET_VEL), .OP_MODE(OP_MODE),
  .CLOSED_LOOP(CLOSED_LOOP), .POWER_EN(POWER_EN), .STEP_OUT(STEP_OUT), .DIR_OUT(DIR_OUT),
  .STORE_TUNING(STORE_TUNING));

// [tb/sdms_pins.sv]
`timescale 1ns/1ns
// Enable, direction, step and analog sources
module sdms_pins (
  input wire        CLOCK,
  input wire        en,
  input wire        dir,
  input wire        run,
  input wire [11:0] adc,
  output reg        EN_PIN = 1'b0,
  output reg        DIR_PIN = 1'b0,
  output reg        STEP_PIN = 1'b0,
  output reg [11:0] ADC_CODE = 12'h000
);
  // Step pulses toggle each cycle while run is set
  always @(posedge CLOCK) begin
    EN_PIN <= en;
    DIR_PIN <= dir;
    ADC_CODE <= adc;
    STEP_PIN <= run & ~STEP_PIN;
  end
endmodule // sdms_pins

// [tb/sdms_top_tb.sv]
`timescale 1ns/1ns
// Self-checking bench of the drive mode block
module sdms_top_tb;
  reg         CLOCK, RSTN, WR, RD, SETUP_OK, en, dir, run, s;
  reg  [7:0]  ADDR;
  reg  [31:0] WDATA, SETUP_RESULT, rdat;
  reg  [11:0] adc;
  wire        EN_PIN, DIR_PIN, STEP_PIN, CLOSED_LOOP, POWER_EN, STEP_OUT, DIR_OUT, STORE_DRIVE;
  wire        STORE_TUNING;
  wire [11:0] ADC_CODE;
  wire [31:0] RDATA, TARGET_VEL;
  wire [7:0]  OP_MODE;
  integer     failures, checks_done, i, n;
  sdms_pins i_pins (.CLOCK(CLOCK), .en(en), .dir(dir), .run(run), .adc(adc), .EN_PIN(EN_PIN),
    .DIR_PIN(DIR_PIN), .STEP_PIN(STEP_PIN), .ADC_CODE(ADC_CODE));
  sdms_top i_dut (.CLOCK(CLOCK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .EN_PIN(EN_PIN), .DIR_PIN(DIR_PIN), .STEP_PIN(STEP_PIN), .ADC_CODE(ADC_CODE),
    .SETUP_OK(SETUP_OK), .SETUP_RESULT(SETUP_RESULT), .TARGET_VEL(TARGET_VEL), .OP_MODE(OP_MODE),
    .CLOSED_LOOP(CLOSED_LOOP), .POWER_EN(POWER_EN), .STEP_OUT(STEP_OUT), .DIR_OUT(DIR_OUT),
    .STORE_DRIVE(STORE_DRIVE), .STORE_TUNING(STORE_TUNING));
  // Clock at 125 MHz
  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge CLOCK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLOCK);
      WR <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge CLOCK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1 rdat = RDATA;
    end
  endtask
  task settle;
    begin
      repeat (7) @(posedge CLOCK);
      #1;
    end
  endtask
  task mode(input [7:0] m);
    begin
      wr(8'h00, {24'h0, m});
      settle;
    end
  endtask
  task vel(input [7:0] m, input [11:0] a, input d, input [31:0] exp);
    begin
      @(posedge CLOCK);
      adc <= a;
      dir <= d;
      mode(m);
      cmp(TARGET_VEL, exp);
    end
  endtask
  task hm(input [7:0] m, input exp);
    begin
      wr(8'h08, {24'h0, m});
      rd(8'h1C);
      cmp(rdat[5], exp);
    end
  endtask
  task t_decode;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        mode(8'h10 | i);
        cmp(CLOSED_LOOP, i[3]);
        cmp(OP_MODE, i[2] ? 8'h02 : 8'hFF);
      end
      $display("decode test done");
    end
  endtask
  task t_analog;
    begin
      vel(8'h14, 12'hFFF, 1'b0, 32'h3E8);
      vel(8'h14, 12'hFFF, 1'b1, 32'hFFFFFC18);
      vel(8'h14, 12'h008, 1'b0, 32'h0);
      vel(8'h14, 12'h7FF, 1'b0, 32'h1F3);
      vel(8'h1D, 12'hFFF, 1'b0, 32'h64);
      wr(8'h14, 32'h2);
      vel(8'h14, 12'hFFF, 1'b0, 32'h1F4);
      wr(8'h14, 32'h1);
      vel(8'h16, 12'h807, 1'b0, 32'h0);
      vel(8'h1E, 12'h7F7, 1'b0, 32'h0);
      vel(8'h16, 12'h809, 1'b1, 32'h4);
      vel(8'h17, 12'h000, 1'b0, 32'hFFFFFF9C);
      rd(8'h18);
      cmp(rdat, 32'hFFFFFF9C);
      $display("analog test done");
    end
  endtask
  task t_run;
    begin
      @(posedge CLOCK);
      en <= 1'b1;
      mode(8'h12);
      cmp(TARGET_VEL, 32'h1E);
      mode(8'h1B);
      cmp(TARGET_VEL, 32'hFFFFFFE2);
      cmp(POWER_EN, 1'b1);
      @(posedge CLOCK);
      en <= 1'b0;
      wr(8'h0C, 32'hF);
      settle;
      cmp(TARGET_VEL, 32'h0);
      cmp(POWER_EN, 1'b0);
      mode(8'h00);
      cmp(POWER_EN, 1'b0);
      wr(8'h0C, 32'hF);
      settle;
      cmp(POWER_EN, 1'b1);
      rd(8'h1C);
      cmp(rdat, 32'h00000108);
      wr(8'h0C, 32'h0);
      $display("test run done");
    end
  endtask
  task t_step;
    begin
      @(posedge CLOCK);
      dir <= 1'b1;
      mode(8'h18);
      n = 0;
      s = STEP_OUT;
      run <= 1'b1;
      fork
        begin
          repeat (8) @(posedge CLOCK);
          run <= 1'b0;
        end
        repeat (16) begin
          @(posedge CLOCK);
          #1 if (STEP_OUT !== s) n = n + 1;
          s = STEP_OUT;
        end
      join
      cmp(n, 8);
      cmp(DIR_OUT, 1'b1);
      mode(8'h14);
      cmp(DIR_OUT, 1'b0);
      $display("step test done");
    end
  endtask
  task t_limit;
    begin
      mode(8'h00);
      wr(8'h04, 32'h04);
      rd(8'h1C);
      cmp(rdat[4], 1'b1);
      wr(8'h04, 32'h0A);
      settle;
      cmp(OP_MODE, 8'h01);
      wr(8'h04, 32'h03);
      settle;
      cmp(OP_MODE, 8'h03);
      hm(8'hFC, 1'b1);
      hm(8'hFB, 1'b0);
      hm(8'hFF, 1'b1);
      hm(8'h01, 1'b0);
      mode(8'h20);
      wr(8'h04, 32'h04);
      settle;
      cmp(OP_MODE, 8'h04);
      wr(8'h04, 32'h01);
      $display("limit test done");
    end
  endtask
  task t_setup;
    begin
      @(posedge CLOCK);
      SETUP_OK <= 1'b1;
      SETUP_RESULT <= 32'hA5C30F96;
      @(posedge CLOCK);
      SETUP_OK <= 1'b0;
      #1 cmp(STORE_DRIVE & STORE_TUNING, 1'b1);
      rd(8'h20);
      cmp(rdat, 32'hA5C30F96);
      rd(8'h40);
      cmp(rdat, 32'h0);
      $display("setup test done");
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Watchdog against a hang
  initial begin
    #100000;
    failures = failures + 1;
    complete_run;
  end
  // Reset, then the scenarios
  initial begin
    {RSTN, WR, RD, SETUP_OK, en, dir, run, ADDR, WDATA, SETUP_RESULT, adc} = 0;
    failures = 0;
    checks_done = 0;
    repeat (4) @(posedge CLOCK);
    RSTN <= 1'b1;
    rd(8'h10);
    cmp(rdat, 32'h1);
    cmp(OP_MODE, 8'h01);
    t_decode;
    t_analog;
    t_run;
    t_step;
    t_limit;
    t_setup;
    complete_run;
  end
endmodule // sdms_top_tb
